// ### input_path_config.sv
/*
 * register bank and microphone clock / delay logic for input paths 3..5.
 * assumes an AXI4-Lite master on aclk, a free running audio_clk with its
 * own synchronous reset, and microphones that return data on each edge.
 */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - path 3 codes pick 384k to 6.144M
// - paths 4,5 codes pick 384k to 3.072M
// - codes 000, 001, 111 reserved, undefined
// - code 010/011 caps all paths 48k/96k
// - noise cancel source forces 3.072M clock
// - rate field counts only in digital mode
// - six-bit per-channel delay, 0 to 63, none on path 5 right
// - delay ignored for analog input
// - both channels timed at shared rate
// - bit 15 enables highpass, resets off
// - preamp gain 40h=0dB, 1dB steps to 5Fh
// - path 3 right source differential/single
// - bit 10 picks analog or digital mode
module input_path_config (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [13:0]            s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [13:0]            s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output input_path_pkg::analog_cfg_t analog_cfg,
	output logic [1:0]                  max_rate_limit,
	input  wire logic                   audio_clk,
	input  wire logic                   audio_resetn,
	input  wire logic [2:0]             mic_data_in,
	output logic [2:0]                  mic_clock_out,
	output logic [2:0]                  mic_left_bit,
	output logic [2:0]                  mic_right_bit,
	output logic [2:0]                  mic_bit_strobe
);
	import input_path_pkg::*;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] reg_slot(input logic [11:0] idx);
		case (idx)
			IDX_PATH3_LEFT_CONTROL:      reg_slot = 4'h0;
			IDX_PATH3_LEFT_PDM_CONTROL:  reg_slot = 4'h1;
			IDX_PATH3_RIGHT_CONTROL:     reg_slot = 4'h2;
			IDX_PATH3_RIGHT_DIGITAL_VOL: reg_slot = 4'h3;
			IDX_PATH3_RIGHT_PDM_CONTROL: reg_slot = 4'h4;
			IDX_PATH4_LEFT_CONTROL:      reg_slot = 4'h5;
			IDX_PATH4_LEFT_PDM_CONTROL:  reg_slot = 4'h6;
			IDX_PATH4_RIGHT_CONTROL:     reg_slot = 4'h7;
			IDX_PATH4_RIGHT_PDM_CONTROL: reg_slot = 4'h8;
			IDX_PATH5_LEFT_CONTROL:      reg_slot = 4'h9;
			IDX_PATH5_LEFT_PDM_CONTROL:  reg_slot = 4'ha;
			IDX_PATH5_RIGHT_CONTROL:     reg_slot = 4'hb;
			IDX_NOISE_CANCEL_SOURCE:     reg_slot = 4'hc;
			IDX_STATUS:                  reg_slot = 4'hd;
			default:                     reg_slot = 4'hf;
		endcase
	endfunction

	function automatic logic [15:0] reg_mask(input logic [3:0] slot);
		case (slot)
			4'h0:                reg_mask = MASK_MODE_ONLY;
			4'h1, 4'h6, 4'ha:    reg_mask = MASK_PDM_RATE;
			4'h2:                reg_mask = MASK_P3R_CTRL;
			4'h3:                reg_mask = MASK_SRC;
			4'h4, 4'h8:          reg_mask = MASK_DLY;
			4'h5, 4'h9:          reg_mask = MASK_HPF_MODE;
			4'h7, 4'hb:          reg_mask = MASK_HPF;
			4'hc:                reg_mask = MASK_ANC;
			default:             reg_mask = RST_ZERO;
		endcase
	endfunction

	function automatic logic [15:0] reg_reset(input logic [3:0] slot);
		case (slot)
			4'h1, 4'h6, 4'ha:    reg_reset = RST_PDM_RATE;
			4'h2:                reg_reset = RST_P3R_CTRL;
			default:             reg_reset = RST_ZERO;
		endcase
	endfunction

	// reserved codes get the 3.072M divider: defined, but not promised
	function automatic logic [4:0] half_sel(input path_cfg_t c,
		input logic is_path3);
		if (c.noise_cancel) begin
			half_sel = HALF_3072;
		end else begin
			case (c.rate_sel)
				RATE_384K:  half_sel = HALF_384;
				RATE_768K:  half_sel = HALF_768;
				RATE_1536K: half_sel = HALF_1536;
				RATE_6144K: half_sel = is_path3 ? HALF_6144 : HALF_3072;
				default:    half_sel = HALF_3072;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [15:0] regs_r [0:12];
	logic        awready_r;
	logic        wready_r;
	logic        aw_full_r;
	logic        w_full_r;
	logic [11:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic [15:0] status_r;
	logic        do_write;
	logic [3:0]  wslot;
	logic [3:0]  rslot;
	logic [15:0] wmask;

	assign do_write = aw_full_r && w_full_r && !bvalid_r;
	assign wslot    = reg_slot(waddr_r);
	assign rslot    = reg_slot(s_axi_araddr[13:2]);
	assign wmask    = reg_mask(wslot)
		& {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	// ----------------------------------------------------------------
	// write channels
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			aw_full_r <= 1'b0;
			waddr_r   <= 12'h000;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			aw_full_r <= 1'b1;
			waddr_r   <= s_axi_awaddr[13:2];
		end else if (do_write) begin
			awready_r <= 1'b1;
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b1;
			w_full_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			w_full_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (do_write) begin
			wready_r <= 1'b1;
			w_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wslot == 4'hf) ? RESP_SLVERR : RESP_OKAY;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// only masked bits store; reserved bits stay zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 13; i++) begin
				regs_r[i] <= reg_reset(4'(i));
			end
		end else if (do_write && wslot < 4'hd) begin
			regs_r[wslot] <= (regs_r[wslot] & ~wmask)
				| (wdata_r[15:0] & wmask);
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= (rslot == 4'hf) ? RESP_SLVERR : RESP_OKAY;
			if (rslot == 4'hd) begin
				rdata_r <= {16'h0000, status_r};
			end else if (rslot < 4'hd) begin
				rdata_r <= {16'h0000, regs_r[rslot]};
			end else begin
				rdata_r <= 32'h0000_0000;
			end
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// ----------------------------------------------------------------
	// path configuration in the bus domain
	// ----------------------------------------------------------------
	path_cfg_t   cfg_now [0:2];
	analog_cfg_t analog_r;
	logic [1:0]  limit_nxt;
	logic [2:0]  anc_active;
	logic [2:0]  rsvd_code;

	always_comb begin
		cfg_now[0].digital      = regs_r[0][MODE_BIT];
		cfg_now[0].rate_sel     = regs_r[1][RATE_MSB:RATE_LSB];
		cfg_now[0].left_delay   = regs_r[1][DLY_MSB:0];
		cfg_now[0].right_delay  = regs_r[4][DLY_MSB:0];
		cfg_now[1].digital      = regs_r[5][MODE_BIT];
		cfg_now[1].rate_sel     = regs_r[6][RATE_MSB:RATE_LSB];
		cfg_now[1].left_delay   = regs_r[6][DLY_MSB:0];
		cfg_now[1].right_delay  = regs_r[8][DLY_MSB:0];
		cfg_now[2].digital      = regs_r[9][MODE_BIT];
		cfg_now[2].rate_sel     = regs_r[10][RATE_MSB:RATE_LSB];
		cfg_now[2].left_delay   = regs_r[10][DLY_MSB:0];
		cfg_now[2].right_delay  = 6'h00;
		for (int p = 0; p < 3; p++) begin
			cfg_now[p].noise_cancel = regs_r[12][p];
		end
	end

	// caps only count for paths really in digital mode
	always_comb begin
		limit_nxt = LIMIT_NONE;
		for (int p = 0; p < 3; p++) begin
			anc_active[p] = cfg_now[p].digital && cfg_now[p].noise_cancel;
			rsvd_code[p]  = cfg_now[p].rate_sel < RATE_384K
				|| cfg_now[p].rate_sel == 3'h7;
			if (cfg_now[p].digital && !cfg_now[p].noise_cancel) begin
				if (cfg_now[p].rate_sel == RATE_384K) begin
					limit_nxt = LIMIT_48K;
				end else if (cfg_now[p].rate_sel == RATE_768K
					&& limit_nxt == LIMIT_NONE) begin
					limit_nxt = LIMIT_96K;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r <= 16'h0000;
		end else begin
			status_r <= {8'h00, rsvd_code, anc_active, limit_nxt};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_r <= '0;
			analog_r.path3_right_preamp_gain <=
				RST_P3R_CTRL[GAIN_MSB:GAIN_LSB];
		end else begin
			analog_r.input_kind <= {cfg_now[2].digital,
				cfg_now[1].digital, cfg_now[0].digital};
			analog_r.highpass_en <= {regs_r[11][HPF_BIT],
				regs_r[9][HPF_BIT], regs_r[7][HPF_BIT],
				regs_r[5][HPF_BIT], regs_r[2][HPF_BIT]};
			analog_r.path3_right_preamp_gain <=
				regs_r[2][GAIN_MSB:GAIN_LSB];
			analog_r.path3_right_source_sel <=
				regs_r[3][SRC_MSB:SRC_LSB];
		end
	end

	assign analog_cfg     = analog_r;
	assign max_rate_limit = status_r[1:0];

	// ----------------------------------------------------------------
	// configuration handshake to the audio domain
	// ----------------------------------------------------------------
	// word held stable while a request is open, so one toggle suffices
	path_cfg_t  sent_r [0:2];
	logic       req_r;
	logic [2:0] ack_sync_r;
	logic       ack_seen_r;
	logic       seen_a_r;
	logic [2:0] req_sync_a_r;
	path_cfg_t  act_a_r [0:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_sync_r <= 3'h0;
			ack_seen_r <= 1'b0;
		end else begin
			ack_sync_r <= {ack_sync_r[1:0], seen_a_r};
			if (ack_sync_r[1] == ack_sync_r[2]) begin
				ack_seen_r <= ack_sync_r[2];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_r <= 1'b0;
			for (int p = 0; p < 3; p++) begin
				sent_r[p] <= '0;
			end
		end else if (req_r == ack_seen_r
			&& (cfg_now[0] != sent_r[0] || cfg_now[1] != sent_r[1]
			|| cfg_now[2] != sent_r[2])) begin
			req_r <= ~req_r;
			for (int p = 0; p < 3; p++) begin
				sent_r[p] <= cfg_now[p];
			end
		end
	end

	always_ff @(posedge audio_clk) begin
		if (!audio_resetn) begin
			req_sync_a_r <= 3'h0;
			seen_a_r     <= 1'b0;
			for (int p = 0; p < 3; p++) begin
				act_a_r[p] <= '0;
			end
		end else begin
			req_sync_a_r <= {req_sync_a_r[1:0], req_r};
			if (req_sync_a_r[1] == req_sync_a_r[2]
				&& req_sync_a_r[2] != seen_a_r) begin
				seen_a_r <= req_sync_a_r[2];
				for (int p = 0; p < 3; p++) begin
					act_a_r[p] <= sent_r[p];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// microphone clock, capture and delay, one per path
	// ----------------------------------------------------------------
	for (genvar p = 0; p < 3; p++) begin : g_path
		logic [4:0]  cnt_r;
		logic [4:0]  half_r;
		logic        clk_r;
		logic [2:0]  dsync_r;
		logic        dbit_r;
		logic [63:0] line_l_r;
		logic [63:0] line_r_r;
		logic        out_l_r;
		logic        out_r_r;
		logic        strobe_r;
		logic        edge_now;
		logic [63:0] line_r_nxt;

		assign edge_now   = act_a_r[p].digital && cnt_r == half_r;
		assign line_r_nxt = {line_r_r[62:0], dbit_r};

		// analog mode parks the clock low; new divider loads only
		// after a full period so no runt pulse reaches the mic
		always_ff @(posedge audio_clk) begin
			if (!audio_resetn) begin
				cnt_r  <= 5'h00;
				half_r <= HALF_3072;
				clk_r  <= 1'b0;
			end else if (!act_a_r[p].digital) begin
				cnt_r  <= 5'h00;
				clk_r  <= 1'b0;
				half_r <= half_sel(act_a_r[p], p == 0);
			end else if (edge_now) begin
				cnt_r <= 5'h00;
				clk_r <= ~clk_r;
				if (clk_r) begin
					half_r <= half_sel(act_a_r[p], p == 0);
				end
			end else begin
				cnt_r <= cnt_r + 5'h01;
			end
		end

		always_ff @(posedge audio_clk) begin
			if (!audio_resetn) begin
				dsync_r <= 3'h0;
				dbit_r  <= 1'b0;
			end else begin
				dsync_r <= {dsync_r[1:0], mic_data_in[p]};
				if (dsync_r[1] == dsync_r[2]) begin
					dbit_r <= dsync_r[2];
				end
			end
		end

		// left on the rising edge, right on the falling edge
		always_ff @(posedge audio_clk) begin
			if (!audio_resetn) begin
				line_l_r <= 64'h0;
				line_r_r <= 64'h0;
			end else if (edge_now && !clk_r) begin
				line_l_r <= {line_l_r[62:0], dbit_r};
			end else if (edge_now && clk_r) begin
				line_r_r <= line_r_nxt;
			end
		end

		always_ff @(posedge audio_clk) begin
			if (!audio_resetn) begin
				out_l_r  <= 1'b0;
				out_r_r  <= 1'b0;
				strobe_r <= 1'b0;
			end else begin
				strobe_r <= edge_now && clk_r;
				if (edge_now && clk_r) begin
					out_l_r <= line_l_r[act_a_r[p].left_delay];
					out_r_r <= line_r_nxt[act_a_r[p].right_delay];
				end
			end
		end

		assign mic_clock_out[p]  = clk_r;
		assign mic_left_bit[p]   = out_l_r;
		assign mic_right_bit[p]  = out_r_r;
		assign mic_bit_strobe[p] = strobe_r;
	end

endmodule

`default_nettype wire

// ### input_path_config_checker.sv
/* checker: bus answer timing and microphone clock behaviour.
   assumes it is bound to input_path_config and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module input_path_checker
	import input_path_pkg::*;
(
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic                        s_axi_awvalid,
	input wire logic                        s_axi_awready,
	input wire logic                        s_axi_wvalid,
	input wire logic                        s_axi_wready,
	input wire logic [1:0]                  s_axi_bresp,
	input wire logic                        s_axi_bvalid,
	input wire logic                        s_axi_arvalid,
	input wire logic                        s_axi_arready,
	input wire logic [31:0]                 s_axi_rdata,
	input wire logic                        s_axi_rvalid,
	input wire logic                        s_axi_rready,
	input wire input_path_pkg::analog_cfg_t analog_cfg,
	input wire logic [1:0]                  max_rate_limit,
	input wire logic                        audio_clk,
	input wire logic                        audio_resetn,
	input wire logic [2:0]                  mic_clock_out,
	input wire logic [2:0]                  mic_bit_strobe
);
	AST_WR_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
	AST_RD_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read answer missing");
	AST_RD_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	// analog_cfg moves only as a result of a completed write
	AST_CFG_BY_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(analog_cfg) |-> s_axi_bvalid || $past(s_axi_bvalid)
		|| $past(s_axi_bvalid, 2)) else $error("config moved without write");
	AST_LIMIT_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
		max_rate_limit != 2'h3) else $error("bad limit code");
	// an analog path 3 keeps its mic clock still, up to the crossing delay
	AST_ANALOG_QUIET: assert property (@(posedge audio_clk)
		disable iff (!audio_resetn) $changed(mic_clock_out[0])
		|-> analog_cfg.input_kind[0] || $past(analog_cfg.input_kind[0], 48))
		else $error("mic clock runs in analog mode");
	AST_HALF_MIN: assert property (@(posedge audio_clk)
		disable iff (!audio_resetn) $rose(mic_clock_out[0]) |=> mic_clock_out[0])
		else $error("mic clock glitch");
	AST_STROBE_PULSE: assert property (@(posedge audio_clk)
		disable iff (!audio_resetn) mic_bit_strobe[0] |=> !mic_bit_strobe[0])
		else $error("strobe longer than one cycle");
	AST_STROBE_AFTER_FALL: assert property (@(posedge audio_clk)
		disable iff (!audio_resetn)
		$fell(mic_clock_out[0]) && analog_cfg.input_kind[0]
		|-> ##[0:1] mic_bit_strobe[0]) else $error("strobe missing");
	C_ERR: cover property (@(posedge aclk) s_axi_bvalid
		&& s_axi_bresp == RESP_SLVERR);
	C_CAP: cover property (@(posedge aclk) max_rate_limit == LIMIT_48K);
	C_STRB: cover property (@(posedge audio_clk) mic_bit_strobe[0]);
endmodule
bind input_path_config input_path_checker i_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .analog_cfg,
	.max_rate_limit, .audio_clk, .audio_resetn, .mic_clock_out,
	.mic_bit_strobe);
`default_nettype wire

// ### input_path_config_tb.sv
/* testbench: bus tasks, rate table, noise cancel and delay checks.
   assumes mic_model on the mic pins and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module input_path_config_tb;
	import input_path_pkg::*;
	logic        aclk, aresetn, audio_clk, audio_resetn;
	logic [13:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, max_rate_limit;
	analog_cfg_t analog_cfg;
	logic [2:0]  mic_data_in, mic_clock_out, mic_left_bit, mic_right_bit;
	logic [2:0]  mic_bit_strobe, c;
	int          fails = 0;
	int          tests_run = 0;
	int          n;

	input_path_config i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.analog_cfg, .max_rate_limit, .audio_clk, .audio_resetn,
		.mic_data_in, .mic_clock_out, .mic_left_bit, .mic_right_bit,
		.mic_bit_strobe);
	mic_model i_mic (.audio_clk, .mic_clk(mic_clock_out),
		.mic_data(mic_data_in));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// unrelated phase to the bus clock
	initial begin
		audio_clk = 1'b0;
		#1.3;
		forever #6 audio_clk = ~audio_clk;
	end

	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [11:0] i, input logic [15:0] d,
		input logic [1:0] er);
		logic a = 1'b1;
		logic w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (a && s_axi_awready) begin
				a = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (a || w || s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [11:0] i, input logic [15:0] d,
		input logic [1:0] er);
		logic a = 1'b1;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (a && s_axi_arready) begin
				a = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end while (a || s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("read", {14'h0, s_axi_rresp, s_axi_rdata[15:0]}, {14'h0, er, d});
	endtask

	// half period of a mic clock in audio_clk cycles, after settling
	task automatic half(input int p, output int k);
		logic v;
		repeat (300) @(posedge audio_clk);
		v = mic_clock_out[p];
		while (mic_clock_out[p] === v) @(posedge audio_clk);
		v = mic_clock_out[p];
		k = 0;
		while (mic_clock_out[p] === v) begin
			k++;
			@(posedge audio_clk);
		end
	endtask

	task automatic results();
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#200000;
		fails++;
		results();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{aresetn, audio_resetn, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
		s_axi_wstrb = 4'h3;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge audio_clk);
		audio_resetn <= 1'b1;
		rd(IDX_PATH3_LEFT_PDM_CONTROL, 16'h0500, RESP_OKAY);
		rd(IDX_PATH3_RIGHT_CONTROL, 16'h0080, RESP_OKAY);
		wr(IDX_PATH3_RIGHT_CONTROL, 16'h80be, RESP_OKAY);
		rd(IDX_PATH3_RIGHT_CONTROL, 16'h80be, RESP_OKAY);
		wr(IDX_PATH3_RIGHT_DIGITAL_VOL, 16'h2000, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("analog", 32'(analog_cfg), {15'h0, 17'h0037d});
		wr(12'h321, 16'h1234, RESP_SLVERR);
		rd(12'h321, 16'h0000, RESP_SLVERR);
		n = 0;
		repeat (100) begin
			@(posedge audio_clk);
			n += int'(mic_clock_out | mic_bit_strobe);
		end
		chk("analog clock", 32'(n), 32'h0);
		wr(IDX_PATH3_LEFT_CONTROL, 16'h0400, RESP_OKAY);
		wr(IDX_PATH4_LEFT_CONTROL, 16'h0400, RESP_OKAY);
		// only documented codes are programmed
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++) begin
				c = (p == 0 && i == 3) ? RATE_6144K : 3'(i + 2);
				wr(p == 0 ? IDX_PATH3_LEFT_PDM_CONTROL
					: IDX_PATH4_LEFT_PDM_CONTROL, {5'h0, c, 8'h0}, RESP_OKAY);
				half(p, n);
				chk("half", 32'(n), 32'(1 << (7 - int'(c))));
				chk("limit", {30'h0, max_rate_limit}, {30'h0, c == RATE_384K
					? LIMIT_48K : c == RATE_768K ? LIMIT_96K : LIMIT_NONE});
			end
		end
		wr(IDX_PATH3_LEFT_PDM_CONTROL, 16'h023f, RESP_OKAY);
		wr(IDX_NOISE_CANCEL_SOURCE, 16'h0001, RESP_OKAY);
		half(0, n);
		chk("forced half", 32'(n), 32'h4);
		chk("limit", {30'h0, max_rate_limit}, {30'h0, LIMIT_NONE});
		repeat (800) @(posedge audio_clk);
		while (mic_bit_strobe[0] !== 1'b1) @(posedge audio_clk);
		chk("bits", {mic_left_bit[0], mic_right_bit[0]}, 32'h3);
		results();
	end
endmodule
`default_nettype wire

// ### input_path_pkg.sv
/*
 * shared constants and carrier types for the input path 3..5 config block.
 * assumes an AXI4-Lite master on aclk and a free running audio clock.
 */
`default_nettype none

package input_path_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_PATH3_LEFT_CONTROL      = 12'h320;
	localparam logic [11:0] IDX_PATH3_LEFT_PDM_CONTROL  = 12'h322;
	localparam logic [11:0] IDX_PATH3_RIGHT_CONTROL     = 12'h324;
	localparam logic [11:0] IDX_PATH3_RIGHT_DIGITAL_VOL = 12'h325;
	localparam logic [11:0] IDX_PATH3_RIGHT_PDM_CONTROL = 12'h326;
	localparam logic [11:0] IDX_PATH4_LEFT_CONTROL      = 12'h328;
	localparam logic [11:0] IDX_PATH4_LEFT_PDM_CONTROL  = 12'h32a;
	localparam logic [11:0] IDX_PATH4_RIGHT_CONTROL     = 12'h32c;
	localparam logic [11:0] IDX_PATH4_RIGHT_PDM_CONTROL = 12'h32e;
	localparam logic [11:0] IDX_PATH5_LEFT_CONTROL      = 12'h330;
	localparam logic [11:0] IDX_PATH5_LEFT_PDM_CONTROL  = 12'h332;
	localparam logic [11:0] IDX_PATH5_RIGHT_CONTROL     = 12'h334;
	localparam logic [11:0] IDX_NOISE_CANCEL_SOURCE     = 12'h340;
	localparam logic [11:0] IDX_STATUS                  = 12'h341;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int HPF_BIT  = 15;
	localparam int SRC_MSB  = 14;
	localparam int SRC_LSB  = 13;
	localparam int MODE_BIT = 10;
	localparam int RATE_MSB = 10;
	localparam int RATE_LSB = 8;
	localparam int GAIN_MSB = 7;
	localparam int GAIN_LSB = 1;
	localparam int DLY_MSB  = 5;

	// ----------------------------------------------------------------
	// writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] MASK_MODE_ONLY  = 16'h0400;
	localparam logic [15:0] MASK_PDM_RATE   = 16'h073f;
	localparam logic [15:0] MASK_P3R_CTRL   = 16'h80fe;
	localparam logic [15:0] MASK_SRC        = 16'h6000;
	localparam logic [15:0] MASK_DLY        = 16'h003f;
	localparam logic [15:0] MASK_HPF_MODE   = 16'h8400;
	localparam logic [15:0] MASK_HPF        = 16'h8000;
	localparam logic [15:0] MASK_ANC        = 16'h0007;
	localparam logic [15:0] RST_PDM_RATE    = 16'h0500;
	localparam logic [15:0] RST_P3R_CTRL    = 16'h0080;
	localparam logic [15:0] RST_ZERO        = 16'h0000;

	// ----------------------------------------------------------------
	// oversample codes, limits, bus answers
	// ----------------------------------------------------------------
	localparam logic [2:0] RATE_384K  = 3'h2;
	localparam logic [2:0] RATE_768K  = 3'h3;
	localparam logic [2:0] RATE_1536K = 3'h4;
	localparam logic [2:0] RATE_3072K = 3'h5;
	localparam logic [2:0] RATE_6144K = 3'h6;
	localparam logic [1:0] LIMIT_NONE = 2'h0;
	localparam logic [1:0] LIMIT_96K  = 2'h1;
	localparam logic [1:0] LIMIT_48K  = 2'h2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// timing: audio clock and microphone clock half periods
	// ----------------------------------------------------------------
	localparam int AUDIO_CLK_KHZ = 24576;
	localparam int PDM_384_KHZ   = 384;
	localparam int PDM_768_KHZ   = 768;
	localparam int PDM_1536_KHZ  = 1536;
	localparam int PDM_3072_KHZ  = 3072;
	localparam int PDM_6144_KHZ  = 6144;
	localparam logic [4:0] HALF_384  = 5'(AUDIO_CLK_KHZ / (2 * PDM_384_KHZ) - 1);
	localparam logic [4:0] HALF_768  = 5'(AUDIO_CLK_KHZ / (2 * PDM_768_KHZ) - 1);
	localparam logic [4:0] HALF_1536 = 5'(AUDIO_CLK_KHZ / (2 * PDM_1536_KHZ) - 1);
	localparam logic [4:0] HALF_3072 = 5'(AUDIO_CLK_KHZ / (2 * PDM_3072_KHZ) - 1);
	localparam logic [4:0] HALF_6144 = 5'(AUDIO_CLK_KHZ / (2 * PDM_6144_KHZ) - 1);

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       digital;
		logic       noise_cancel;
		logic [2:0] rate_sel;
		logic [5:0] left_delay;
		logic [5:0] right_delay;
	} path_cfg_t;

	typedef struct packed {
		logic [2:0] input_kind;
		logic [4:0] highpass_en;
		logic [6:0] path3_right_preamp_gain;
		logic [1:0] path3_right_source_sel;
	} analog_cfg_t;

endpackage

`default_nettype wire

// ### mic_model.sv
/* model of three pdm microphones answering the mic clocks.
   assumes the mic clocks are divided from audio_clk. */
`timescale 1ns/1ps
`default_nettype none
module mic_model (
	input  wire logic       audio_clk,
	input  wire logic [2:0] mic_clk,
	output var logic  [2:0] mic_data
);
	initial mic_data = 3'h0;
	for (genvar p = 0; p < 3; p++) begin : g_mic
		logic       prev = 1'b0;
		logic [6:0] idle = 7'h7f;
		// idle line toggles so a stale bit never reads as data
		always @(posedge audio_clk) begin
			prev <= mic_clk[p];
			idle <= (prev != mic_clk[p]) ? 7'h0 : idle + 7'(idle != 7'h7f);
			mic_data[p] <= (idle < 7'h46) ? 1'b1 : ~mic_data[p];
		end
	end
endmodule
`default_nettype wire
